// ### rtl/ssp_pkg.sv
// constants and carriers for the synchronous serial port with break receive
// assumes one AHB-Lite slave, 32-bit data, one word per register
package ssp_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SSP_OFS_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] SSP_OFS_RX_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] SSP_OFS_BAUD_DIVISOR_LOW = 8'h08;
  localparam logic [7:0] SSP_OFS_BAUD_DIVISOR_HIGH = 8'h0c;
  localparam logic [7:0] SSP_OFS_TRANSMIT_DATA = 8'h10;
  localparam logic [7:0] SSP_OFS_TX_STATUS_CONTROL = 8'h14;
  localparam logic [7:0] SSP_OFS_RX_DATA = 8'h18;
  localparam logic [7:0] SSP_OFS_FLAGS = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SSP_BC_RX_IDLE = 6;
  localparam int SSP_BC_IDLE_POL = 4;
  localparam int SSP_BC_WIDE_SEL = 3;
  localparam int SSP_BC_WAKE_EDGE = 1;
  localparam int SSP_BC_AUTOBAUD = 0;
  localparam int SSP_RS_PORT_EN = 7;
  localparam int SSP_RS_RX_NINTH_EN = 6;
  localparam int SSP_RS_SINGLE_RX = 5;
  localparam int SSP_RS_CONT_RX = 4;
  localparam int SSP_RS_FRAME_ERR = 2;
  localparam int SSP_RS_OVERRUN = 1;
  localparam int SSP_RS_RX_NINTH_VAL = 0;
  localparam int SSP_TS_MASTER = 7;
  localparam int SSP_TS_TX_NINTH_EN = 6;
  localparam int SSP_TS_TX_EN = 5;
  localparam int SSP_TS_CLOCKED = 4;
  localparam int SSP_TS_HIGH_SPEED = 2;
  localparam int SSP_TS_SHIFT_EMPTY = 1;
  localparam int SSP_TS_TX_NINTH_VAL = 0;
  localparam int SSP_FL_RX_READY = 1;
  localparam int SSP_FL_TX_EMPTY = 0;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SSP_LAST_BIT8 = 4'h7;
  localparam logic [3:0] SSP_LAST_BIT9 = 4'h8;
  localparam logic [3:0] SSP_ASYNC_STOP8 = 4'h9;
  localparam logic [3:0] SSP_ASYNC_STOP9 = 4'ha;
  localparam logic [1:0] SSP_FIFO_DEPTH = 2'h2;
  localparam logic [7:0] SSP_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_ST_IDLE = 2'b01,
    SSP_ST_ASYNC = 2'b10
  } ssp_fsm_t;

  typedef struct packed {
    logic frameErr;
    logic ninth;
    logic [7:0] data;
  } ssp_char_t;

  typedef struct packed {
    logic dataOut;
    logic dataOe;
    logic clockOut;
    logic clockOe;
  } ssp_pins_t;

  typedef struct packed {
    logic idlePolarity;
    logic wideSelect;
    logic wakeOnEdge;
    logic autobaud;
    logic portEnable;
    logic rxNinthEnable;
    logic singleRxEnable;
    logic contRxEnable;
    logic clockMaster;
    logic txNinthEnable;
    logic txEnable;
    logic clockedMode;
    logic baudHighSpeed;
    logic txNinthValue;
    logic [7:0] divisorLo;
    logic [7:0] divisorHi;
    logic [7:0] txData;
    logic txDataFull;
    logic [8:0] txShift;
    logic txBusy;
    logic [8:0] rxShift;
    logic [3:0] bitCnt;
    logic [15:0] baudCnt;
    logic clkActive;
    ssp_char_t [1:0] fifo;
    logic [1:0] fifoCnt;
    logic overrun;
    logic overrunSingle;
    logic wakeFlag;
    ssp_fsm_t fsm;
    logic [1:0] dataSync;
    logic [1:0] clockSync;
    logic dataPrev;
    logic clockPrev;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdData;
    logic readyOut;
    ssp_pins_t pins;
  } ssp_state_t;

endpackage

// ### rtl/ssp_sync_port.sv
// synchronous half-duplex serial port with break receive, AHB-Lite registers
// assumes data and clock pins resolved outside; all logic on one clock
//
// Function
// RL1: break shows as ready flag, framing error and received byte zero
// RL2: wake-on-edge flags first falling edge, clears on rising, then receives normally
// RL3: clocked mode shifts characters with no start or stop bits
// RL4: mode bits select clocked, master or slave, transmit or receive, enable
// RL5: master drives shift clock and enables clock driver in clocked mode
// RL6: master makes exactly one clock cycle per data bit, no extra
// RL7: polarity bit picks clock idle level and the data-change edge
// RL8: data changes on leading edge, valid at trailing edge
// RL9: master transmit drives data and clock pins
// RL10: transmit data waits for shift register, else loads and shifts at once
// RL11: master receive releases the data pin
// RL12: single receive clocks one character then clears its enable
// RL13: continuous receive clocks until cleared, partial character then discarded
// RL14: both receive enables set: single clears after first, continuous goes on
// RL15: trailing-edge samples fill shift register, complete character enters two-deep fifo
// RL16: receive data shows oldest byte; ready flag stays while fifo not empty
// RL17: slave takes clock from the pin and releases the clock driver
// RL18: third character sets overrun, keeps stored two, blocks further reception
// RL19: single-mode overrun clears on data read; continuous clears on disable
// RL20: ninth-bit mode shifts nine bits; ninth shows for oldest character
// RL21: software reads ninth bit before the low byte
// RL22: software programs divisor, mode and enables before writing transmit data
// RL23: transmit-empty flag set while transmit data register can accept
// RL24: shift-empty flag shows whether transmission is active
// RL25: least significant bit first, ninth transmit bit after the eight
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module ssp_sync_port
  import ssp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic dataIn,
  input wire logic clockIn,
  output ssp_pins_t pinOut
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] lastBit(input logic ninth);
    lastBit = ninth ? SSP_LAST_BIT9 : SSP_LAST_BIT8;
  endfunction

  function automatic logic [15:0] divisorOf(input logic wide, input logic [7:0] hi,
                                            input logic [7:0] lo);
    divisorOf = wide ? {hi, lo} : {8'h00, lo};
  endfunction

  ssp_state_t s_reg;
  ssp_state_t s_next;
  logic syncOn;
  logic txMode;
  logic runM;
  logic lead;
  logic trail;
  logic txLoad;
  logic popReq;
  logic readRxData;
  logic charDone;
  logic overrunSet;

  assign hrdata = s_reg.rdData;
  assign hreadyout = s_reg.readyOut;
  assign hresp = 1'b0;
  assign pinOut = s_reg.pins;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic din;
    logic cin;
    logic busPhase;
    logic rxOn;
    logic asyncOn;
    logic nSync;
    logic [15:0] div;
    logic [15:0] target;
    logic [8:0] word;
    logic [7:0] rd;
    logic [1:0] cnt;
    logic [3:0] stopIdx;
    ssp_char_t ch;
    s_next = s_reg;
    din = s_reg.dataSync[1];
    cin = s_reg.clockSync[1];
    busPhase = hsel && hready && htrans[1];
    rxOn = 1'b0;
    asyncOn = 1'b0;
    nSync = 1'b0;
    div = divisorOf(s_reg.wideSelect, s_reg.divisorHi, s_reg.divisorLo);
    target = div;
    word = s_reg.rxShift;
    rd = SSP_REG_RESET;
    cnt = s_reg.fifoCnt;
    stopIdx = s_reg.rxNinthEnable ? SSP_ASYNC_STOP9 : SSP_ASYNC_STOP8;
    ch = '0;
    lead = 1'b0;
    trail = 1'b0;
    txLoad = 1'b0;
    charDone = 1'b0;
    overrunSet = 1'b0;
    s_next.dataSync = {s_reg.dataSync[0], dataIn};
    s_next.clockSync = {s_reg.clockSync[0], clockIn};
    s_next.dataPrev = din;
    s_next.clockPrev = cin;
    s_next.readyOut = 1'b1;
    syncOn = s_reg.portEnable && s_reg.clockedMode; // RL4
    txMode = !(s_reg.singleRxEnable || s_reg.contRxEnable); // RL4

    // bus address phase
    s_next.wrPend = busPhase && hwrite;
    if (busPhase && hwrite) begin
      s_next.wrAddr = haddr[7:0];
    end
    readRxData = busPhase && !hwrite && (haddr[7:0] == SSP_OFS_RX_DATA);
    popReq = readRxData && (s_reg.fifoCnt != 2'h0);
    if (busPhase && !hwrite) begin
      case (haddr[7:0])
        SSP_OFS_BAUD_CONTROL: begin
          rd[SSP_BC_RX_IDLE] = (s_reg.fsm == SSP_ST_IDLE);
          rd[SSP_BC_IDLE_POL] = s_reg.idlePolarity;
          rd[SSP_BC_WIDE_SEL] = s_reg.wideSelect;
          rd[SSP_BC_WAKE_EDGE] = s_reg.wakeOnEdge;
          rd[SSP_BC_AUTOBAUD] = s_reg.autobaud;
        end
        SSP_OFS_RX_STATUS_CONTROL: begin
          rd[SSP_RS_PORT_EN] = s_reg.portEnable;
          rd[SSP_RS_RX_NINTH_EN] = s_reg.rxNinthEnable;
          rd[SSP_RS_SINGLE_RX] = s_reg.singleRxEnable;
          rd[SSP_RS_CONT_RX] = s_reg.contRxEnable;
          rd[SSP_RS_FRAME_ERR] = (s_reg.fifoCnt != 2'h0) && s_reg.fifo[0].frameErr; // RL1
          rd[SSP_RS_OVERRUN] = s_reg.overrun;
          rd[SSP_RS_RX_NINTH_VAL] = (s_reg.fifoCnt != 2'h0) && s_reg.fifo[0].ninth; // RL20
        end
        SSP_OFS_BAUD_DIVISOR_LOW: rd = s_reg.divisorLo;
        SSP_OFS_BAUD_DIVISOR_HIGH: rd = s_reg.divisorHi;
        SSP_OFS_TX_STATUS_CONTROL: begin
          rd[SSP_TS_MASTER] = s_reg.clockMaster;
          rd[SSP_TS_TX_NINTH_EN] = s_reg.txNinthEnable;
          rd[SSP_TS_TX_EN] = s_reg.txEnable;
          rd[SSP_TS_CLOCKED] = s_reg.clockedMode;
          rd[SSP_TS_HIGH_SPEED] = s_reg.baudHighSpeed;
          rd[SSP_TS_SHIFT_EMPTY] = !s_reg.txBusy; // RL24
          rd[SSP_TS_TX_NINTH_VAL] = s_reg.txNinthValue;
        end
        SSP_OFS_RX_DATA: begin
          if (s_reg.fifoCnt != 2'h0) begin
            rd = s_reg.fifo[0].data; // RL16
          end
        end
        SSP_OFS_FLAGS: begin
          rd[SSP_FL_RX_READY] = (s_reg.fifoCnt != 2'h0) || s_reg.wakeFlag; // RL16
          rd[SSP_FL_TX_EMPTY] = !s_reg.txDataFull; // RL23
        end
        default: rd = SSP_REG_RESET;
      endcase
      s_next.rdData = {24'h000000, rd};
    end

    // reading the data register pops the fifo and clears read-cleared events
    if (readRxData) begin
      s_next.wakeFlag = 1'b0;
      if (s_reg.overrun && s_reg.overrunSingle) begin
        s_next.overrun = 1'b0; // RL19
      end
    end
    if (popReq) begin
      s_next.fifo[0] = s_reg.fifo[1];
      s_next.fifoCnt = s_reg.fifoCnt - 2'h1;
    end
    cnt = s_next.fifoCnt;

    // ----------------------------------------------------------------
    // transmit load and clock generation
    // ----------------------------------------------------------------
    if (syncOn && txMode && s_reg.txEnable && s_reg.txDataFull && !s_reg.txBusy) begin
      txLoad = 1'b1; // RL10
      s_next.txShift = {s_reg.txNinthValue, s_reg.txData}; // RL25
      s_next.txBusy = 1'b1;
      s_next.txDataFull = 1'b0; // RL23
      s_next.bitCnt = 4'h0;
    end
    runM = syncOn && s_reg.clockMaster && (txMode ? s_reg.txBusy : !s_reg.overrun); // RL6
    if (runM) begin
      if (s_reg.baudCnt >= div) begin
        s_next.baudCnt = 16'h0000;
        s_next.clkActive = !s_reg.clkActive; // RL5
        lead = !s_reg.clkActive;
        trail = s_reg.clkActive;
      end else begin
        s_next.baudCnt = s_reg.baudCnt + 16'h0001;
      end
    end else if (s_reg.fsm != SSP_ST_ASYNC) begin
      s_next.baudCnt = 16'h0000;
      s_next.clkActive = 1'b0;
      if (syncOn && s_reg.clockMaster) begin
        s_next.bitCnt = 4'h0; // RL13
      end
    end
    if (syncOn && !s_reg.clockMaster) begin
      lead = (cin ^ s_reg.idlePolarity) && !(s_reg.clockPrev ^ s_reg.idlePolarity); // RL17
      trail = !(cin ^ s_reg.idlePolarity) && (s_reg.clockPrev ^ s_reg.idlePolarity);
    end

    // ----------------------------------------------------------------
    // clocked shifting
    // ----------------------------------------------------------------
    rxOn = !txMode && !s_reg.overrun && (s_reg.clockMaster || s_reg.contRxEnable); // RL18
    if (lead && txMode && s_reg.txBusy) begin
      s_next.pins.dataOut = s_reg.txShift[0]; // RL8
      s_next.txShift = {1'b0, s_reg.txShift[8:1]}; // RL25
    end
    if (trail) begin
      if (txMode && s_reg.txBusy) begin
        if (s_reg.bitCnt == lastBit(s_reg.txNinthEnable)) begin
          s_next.txBusy = 1'b0; // RL24
          s_next.bitCnt = 4'h0;
        end else begin
          s_next.bitCnt = s_reg.bitCnt + 4'h1;
        end
      end else if (rxOn) begin
        word[s_reg.bitCnt] = din; // RL15
        s_next.rxShift = word;
        if (s_reg.bitCnt == lastBit(s_reg.rxNinthEnable)) begin
          charDone = 1'b1; // RL3
          s_next.bitCnt = 4'h0;
          s_next.singleRxEnable = 1'b0; // RL12 RL14
        end else begin
          s_next.bitCnt = s_reg.bitCnt + 4'h1;
        end
      end
    end

    // ----------------------------------------------------------------
    // framed receive, used to catch a break
    // ----------------------------------------------------------------
    asyncOn = s_reg.portEnable && !s_reg.clockedMode && s_reg.contRxEnable &&
              !s_reg.overrun && !s_reg.wakeOnEdge;
    case (s_reg.fsm)
      SSP_ST_IDLE: begin
        if (asyncOn && !din && s_reg.dataPrev) begin
          s_next.fsm = SSP_ST_ASYNC;
          s_next.baudCnt = 16'h0000;
          s_next.bitCnt = 4'h0;
          s_next.clkActive = 1'b0;
        end
      end
      SSP_ST_ASYNC: begin
        target = s_reg.clkActive ? div : {1'b0, div[15:1]};
        if (!asyncOn) begin
          s_next.fsm = SSP_ST_IDLE;
          s_next.bitCnt = 4'h0;
          s_next.clkActive = 1'b0;
        end else if (s_reg.baudCnt >= target) begin
          s_next.baudCnt = 16'h0000;
          s_next.clkActive = 1'b1;
          if (s_reg.bitCnt == 4'h0) begin
            if (din) begin
              s_next.fsm = SSP_ST_IDLE;
              s_next.clkActive = 1'b0;
            end else begin
              s_next.bitCnt = 4'h1;
            end
          end else if (s_reg.bitCnt == stopIdx) begin
            charDone = 1'b1;
            ch.frameErr = !din; // RL1
            s_next.fsm = SSP_ST_IDLE;
            s_next.clkActive = 1'b0;
            s_next.bitCnt = 4'h0;
          end else begin
            word[s_reg.bitCnt - 4'h1] = din;
            s_next.rxShift = word;
            s_next.bitCnt = s_reg.bitCnt + 4'h1;
          end
        end else begin
          s_next.baudCnt = s_reg.baudCnt + 16'h0001;
        end
      end
      default: s_next.fsm = SSP_ST_IDLE;
    endcase

    // fifo push; a full fifo turns the character into an overrun
    ch.data = word[7:0];
    ch.ninth = s_reg.rxNinthEnable && word[8]; // RL20
    if (charDone) begin
      if (cnt == SSP_FIFO_DEPTH) begin
        s_next.overrun = 1'b1; // RL18
        s_next.overrunSingle = !s_reg.contRxEnable;
        overrunSet = 1'b1;
      end else begin
        s_next.fifo[cnt[0]] = ch; // RL15
        s_next.fifoCnt = cnt + 2'h1;
      end
    end

    // wake on edge: falling edge flags, rising edge ends the break
    if (s_reg.portEnable && !s_reg.clockedMode && s_reg.wakeOnEdge) begin
      if (!din && s_reg.dataPrev) begin
        s_next.wakeFlag = 1'b1; // RL2
      end
      if (din && !s_reg.dataPrev) begin
        s_next.wakeOnEdge = 1'b0; // RL2
      end
    end

    // ----------------------------------------------------------------
    // bus data phase writes
    // ----------------------------------------------------------------
    if (s_reg.wrPend) begin
      case (s_reg.wrAddr)
        SSP_OFS_BAUD_CONTROL: begin
          s_next.idlePolarity = hwdata[SSP_BC_IDLE_POL];
          s_next.wideSelect = hwdata[SSP_BC_WIDE_SEL];
          s_next.wakeOnEdge = hwdata[SSP_BC_WAKE_EDGE];
          s_next.autobaud = hwdata[SSP_BC_AUTOBAUD];
        end
        SSP_OFS_RX_STATUS_CONTROL: begin
          s_next.portEnable = hwdata[SSP_RS_PORT_EN];
          s_next.rxNinthEnable = hwdata[SSP_RS_RX_NINTH_EN];
          s_next.singleRxEnable = hwdata[SSP_RS_SINGLE_RX];
          s_next.contRxEnable = hwdata[SSP_RS_CONT_RX];
          if (!hwdata[SSP_RS_CONT_RX] && s_reg.overrun && !s_reg.overrunSingle &&
              !overrunSet) begin
            s_next.overrun = 1'b0; // RL19
          end
        end
        SSP_OFS_BAUD_DIVISOR_LOW: s_next.divisorLo = hwdata[7:0];
        SSP_OFS_BAUD_DIVISOR_HIGH: s_next.divisorHi = hwdata[7:0];
        SSP_OFS_TRANSMIT_DATA: begin
          s_next.txData = hwdata[7:0]; // RL10
          s_next.txDataFull = 1'b1;
        end
        SSP_OFS_TX_STATUS_CONTROL: begin
          s_next.clockMaster = hwdata[SSP_TS_MASTER];
          s_next.txNinthEnable = hwdata[SSP_TS_TX_NINTH_EN];
          s_next.txEnable = hwdata[SSP_TS_TX_EN];
          s_next.clockedMode = hwdata[SSP_TS_CLOCKED];
          s_next.baudHighSpeed = hwdata[SSP_TS_HIGH_SPEED];
          s_next.txNinthValue = hwdata[SSP_TS_TX_NINTH_VAL];
        end
        default: s_next.wrPend = s_next.wrPend;
      endcase
    end

    // disabling the port resets it, configuration stays
    if (!s_next.portEnable) begin
      s_next.fifoCnt = 2'h0;
      s_next.overrun = 1'b0; // RL19
      s_next.txDataFull = 1'b0;
      s_next.txBusy = 1'b0;
      s_next.bitCnt = 4'h0;
      s_next.baudCnt = 16'h0000;
      s_next.clkActive = 1'b0;
      s_next.wakeFlag = 1'b0;
      s_next.fsm = SSP_ST_IDLE;
    end

    // pin drivers follow the configuration
    nSync = s_next.portEnable && s_next.clockedMode;
    s_next.pins.clockOe = nSync && s_next.clockMaster; // RL5
    s_next.pins.dataOe = nSync && !(s_next.singleRxEnable || s_next.contRxEnable); // RL9 RL11
    s_next.pins.clockOut = (nSync && s_next.clkActive) ^ s_next.idlePolarity; // RL7
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.fsm <= SSP_ST_IDLE;
      s_reg.readyOut <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] leadCount;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      leadCount <= 4'h0;
    end else if (ce) begin
      if (txLoad) begin
        leadCount <= 4'h0;
      end else if (lead && s_reg.txBusy) begin
        leadCount <= leadCount + 4'h1;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  clock_oe_a: assert property (syncOn |-> s_reg.pins.clockOe == s_reg.clockMaster) // RL5
    else $error("clock driver enable does not follow master mode");
  data_oe_a: assert property (syncOn && !txMode |-> !s_reg.pins.dataOe) // RL11
    else $error("data driver enabled during receive");
  tx_oe_a: assert property (syncOn && txMode |-> s_reg.pins.dataOe) // RL9
    else $error("data driver off during transmit");
  bit_clocks_a: assert property ($fell(s_reg.txBusy) && s_reg.portEnable &&
      s_reg.clockMaster |-> leadCount == lastBit(s_reg.txNinthEnable) + 4'h1) // RL6
    else $error("wrong number of clock cycles for a character");
  lead_data_a: assert property ($changed(s_reg.pins.dataOut) && s_reg.pins.clockOe |->
      $changed(s_reg.pins.clockOut) && s_reg.pins.clockOut != s_reg.idlePolarity) // RL8
    else $error("data changed away from leading clock edge");
  idle_clock_a: assert property ((s_reg.pins.clockOe && txMode && !s_reg.txBusy)[*2] |->
      s_reg.pins.clockOut == s_reg.idlePolarity) // RL7
    else $error("clock not at idle level");
  single_stop_a: assert property ($fell(s_reg.singleRxEnable) && !$past(s_reg.wrPend) |->
      $past(charDone)) // RL12
    else $error("single receive cleared without a character");
  cont_stop_a: assert property ($fell(s_reg.contRxEnable) && syncOn && s_reg.clockMaster &&
      !s_reg.singleRxEnable && ce |=> s_reg.bitCnt == 4'h0 && !s_reg.clkActive) // RL13
    else $error("clock kept running after continuous receive stopped");
  overrun_full_a: assert property ($rose(s_reg.overrun) |->
      s_reg.fifoCnt == SSP_FIFO_DEPTH && $stable(s_reg.fifo)) // RL18
    else $error("overrun without a full fifo");
  rx_data_a: assert property (readRxData && ce && s_reg.fifoCnt != 2'h0 |=>
      hrdata[7:0] == $past(s_reg.fifo[0].data)) // RL16
    else $error("receive data is not the oldest character");

  tx_done_c: cover property ($fell(s_reg.txBusy) && s_reg.clockMaster);
  overrun_c: cover property (overrunSet);
  break_c: cover property (charDone && s_reg.fsm == SSP_ST_ASYNC && s_reg.rxShift[7:0] == 8'h00);
  wake_c: cover property ($rose(s_reg.wakeFlag));

endmodule

`default_nettype wire

// ### tb/ssp_remote_dev.sv
// remote synchronous device on the port's resolved data and clock wires
// assumes the clock wire idles at pol; a leading edge leaves the idle level
`timescale 1ns/10ps
`default_nettype none
module ssp_remote_dev (
  input wire logic linkClk,
  input wire logic pol,
  input wire logic dataWire,
  input wire logic restart,
  input wire logic [7:0] txByte,
  output var logic dataDrv,
  output var logic [31:0] rxWord,
  output var int nBits
);
  int idx;
  initial begin
    dataDrv = 1'b0;
    rxWord = '0;
    nBits = 0;
    idx = 0;
  end
  always @(posedge restart) idx = 0;
  // leading edge: next bit out, lsb first, no framing; trailing edge: sample
  always @(linkClk) begin
    if (linkClk !== pol) begin
      dataDrv = txByte[idx % 8];
      idx++;
    end else begin
      rxWord = {dataWire, rxWord[31:1]};
      nBits++;
    end
  end
endmodule
`default_nettype wire

// ### tb/test_ssp_sync_port.sv
// bench for the serial port: ahb-lite master, remote device, read checks
// assumes ssp_pkg, the port and the remote device compiled first
`timescale 1ns/10ps
`default_nettype none
module test_ssp_sync_port import ssp_pkg::*;;
  logic clock, reset, hsel, hwrite, rdPhase, pol, restart, clkWire;
  logic hreadyout, hresp, dataWire, dataDrv;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rxWord, seed, e;
  logic [7:0] b1, b2;
  logic [1:0] brk;
  logic [31:0] expQ[$];
  ssp_pins_t pinOut;
  int n_errors, total_checks, nBits, n0, nb;
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  assign dataWire = pinOut.dataOe ? pinOut.dataOut : (brk[1] ? brk[0] : dataDrv);
  assign clkWire = pinOut.clockOe ? pinOut.clockOut : pol;
  ssp_sync_port u_ssp_sync_port (.clock(clock), .reset(reset), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dataIn(dataWire), .clockIn(clkWire), .pinOut(pinOut));
  ssp_remote_dev u_ssp_remote_dev (.linkClk(clkWire), .pol(pol), .dataWire(dataWire),
    .restart(restart), .txByte(b1), .dataDrv(dataDrv), .rxWord(rxWord), .nBits(nBits));
  task automatic check(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rdPhase <= !w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdPhase <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expQ.push_back(x);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic waitBits(input int n);
    for (int i = 0; i < 3000 && nBits < n; i++) @(posedge clock);
  endtask
  // read data compared in its data phase
  always @(posedge clock)
    if (rdPhase === 1'b1 && hreadyout === 1'b1) begin
      check(hrdata, expQ.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
  initial begin
    #4000000;
    n_errors++;
    stop_test();
  end
  initial begin
    seed = 32'hf9d07251;
    reset = 1'b1;
    hsel = 1'b1;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = '0;
    hwdata = '0;
    rdPhase = 1'b0;
    pol = 1'b0;
    restart = 1'b0;
    brk = 2'b00;
    b1 = 8'h0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    b2 = $random(seed);
    wr(SSP_OFS_BAUD_DIVISOR_LOW, {24'h0, b2});
    rd(SSP_OFS_BAUD_DIVISOR_LOW, {24'h0, b2});
    rd(8'h20, 32'h0);
    rd(SSP_OFS_TRANSMIT_DATA, 32'h0);
    wr(SSP_OFS_BAUD_DIVISOR_LOW, 32'h3);
    wr(SSP_OFS_RX_STATUS_CONTROL, 32'h80);
    // master transmit, both polarities, two chars back to back
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      nb = 8 + p;
      b1 = $random(seed);
      b2 = $random(seed);
      wr(SSP_OFS_BAUD_CONTROL, {27'h0, p[0], 4'h0});
      e = {24'h0, 1'b1, p[0], 1'b1, 1'b1, 3'h0, p[0]};
      wr(SSP_OFS_TX_STATUS_CONTROL, e);
      n0 = nBits;
      wr(SSP_OFS_TRANSMIT_DATA, {24'h0, b1});
      wr(SSP_OFS_TRANSMIT_DATA, {24'h0, b2});
      waitBits(n0 + 3);
      check({30'h0, pinOut.dataOe, pinOut.clockOe}, 32'h3);
      waitBits(n0 + 2 * nb);
      repeat (12) @(posedge clock);
      check(rxWord >> (32 - 2 * nb), p ? {14'h0, 1'b1, b2, 1'b1, b1} : {16'h0, b2, b1});
      check(nBits - n0, 2 * nb);
      check({31'h0, pinOut.clockOut}, p);
      rd(SSP_OFS_TX_STATUS_CONTROL, e | 32'h2);
      rd(SSP_OFS_FLAGS, 32'h1);
    end
    // single nine-bit receive, then continuous into overrun
    b1 = $random(seed);
    wr(SSP_OFS_TX_STATUS_CONTROL, 32'h90);
    restart <= 1'b1;
    n0 = nBits;
    wr(SSP_OFS_RX_STATUS_CONTROL, 32'he0);
    restart <= 1'b0;
    waitBits(n0 + 3);
    check({30'h0, pinOut.dataOe, pinOut.clockOe}, 32'h1);
    waitBits(n0 + 9);
    repeat (12) @(posedge clock);
    check(nBits - n0, 9);
    rd(SSP_OFS_RX_STATUS_CONTROL, {24'h0, 7'h60, b1[0]});
    rd(SSP_OFS_FLAGS, 32'h3);
    rd(SSP_OFS_RX_DATA, {24'h0, b1});
    rd(SSP_OFS_FLAGS, 32'h1);
    b1 = $random(seed);
    restart <= 1'b1;
    n0 = nBits;
    wr(SSP_OFS_RX_STATUS_CONTROL, 32'h90);
    waitBits(n0 + 24);
    repeat (60) @(posedge clock);
    check(nBits - n0, 24);
    rd(SSP_OFS_RX_STATUS_CONTROL, 32'h92);
    rd(SSP_OFS_RX_DATA, {24'h0, b1});
    rd(SSP_OFS_RX_DATA, {24'h0, b1});
    wr(SSP_OFS_RX_STATUS_CONTROL, 32'h80);
    rd(SSP_OFS_RX_STATUS_CONTROL, 32'h80);
    // slave releases the clock pin; then a framed break and a wake on edge
    wr(SSP_OFS_TX_STATUS_CONTROL, 32'h10);
    @(posedge clock);
    check({30'h0, pinOut.dataOe, pinOut.clockOe}, 32'h2);
    brk <= 2'b11;
    wr(SSP_OFS_TX_STATUS_CONTROL, 32'h0);
    wr(SSP_OFS_RX_STATUS_CONTROL, 32'h90);
    repeat (8) @(posedge clock);
    brk <= 2'b10;
    repeat (60) @(posedge clock);
    brk <= 2'b11;
    repeat (8) @(posedge clock);
    rd(SSP_OFS_FLAGS, 32'h3);
    rd(SSP_OFS_RX_STATUS_CONTROL, 32'h94);
    rd(SSP_OFS_RX_DATA, 32'h0);
    wr(SSP_OFS_BAUD_CONTROL, 32'h2);
    brk <= 2'b10;
    repeat (8) @(posedge clock);
    rd(SSP_OFS_FLAGS, 32'h3);
    brk <= 2'b11;
    repeat (8) @(posedge clock);
    rd(SSP_OFS_BAUD_CONTROL, 32'h40);
    rd(SSP_OFS_RX_DATA, 32'h0);
    rd(SSP_OFS_FLAGS, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
